// file: shared/agg_defines.svh
// Register map, field positions, reset values, event codes and timing constants of the aggregator.
`ifndef AGG_DEFINES_SVH
`define AGG_DEFINES_SVH

`define AGG_APB_AW 8
`define AGG_APB_DW 32
`define AGG_STAMP_W 32

`define AGG_OFF_CTRL 8'h00
`define AGG_OFF_STATUS 8'h04
`define AGG_OFF_START_CNT 8'h08
`define AGG_OFF_TRIP_CNT 8'h0C
`define AGG_OFF_CNT_CLR 8'h10
`define AGG_OFF_XSTART_ASSIGN 8'h14
`define AGG_OFF_XTRIP_ASSIGN 8'h18
`define AGG_OFF_IRQ_STATUS 8'h1C
`define AGG_OFF_IRQ_MASK 8'h20
`define AGG_OFF_TIME 8'h24

`define AGG_CTRL_FORCE_LSB 0
`define AGG_CTRL_FORCE_MSB 1
`define AGG_CTRL_REC_LSB 4
`define AGG_CTRL_REC_MSB 7
`define AGG_CTRL_RESET 32'h0000_00F0

`define AGG_STAT_COND_LSB 0
`define AGG_STAT_COND_MSB 2
`define AGG_STAT_START_BIT 4
`define AGG_STAT_TRIP_BIT 5
`define AGG_STAT_FORCE_OK_BIT 6

`define AGG_CLR_START_BIT 0
`define AGG_CLR_TRIP_BIT 1

`define AGG_EVT_START_ON 2'h0
`define AGG_EVT_START_OFF 2'h1
`define AGG_EVT_TRIP_ON 2'h2
`define AGG_EVT_TRIP_OFF 2'h3
`define AGG_N_EVT 4

`define AGG_CLK_NS 10
`define AGG_TICK_NS 1000000
`define AGG_TICK_CYCLES (`AGG_TICK_NS / `AGG_CLK_NS)

`endif

// file: shared/agg_pkg.sv
// Types shared by the aggregator modules.
`include "agg_defines.svh"

package agg_pkg;
	typedef enum logic [1:0] {
		FORCE_NORMAL = 2'h0,
		FORCE_START = 2'h1,
		FORCE_TRIP = 2'h2
	} force_sel_t;

	typedef enum logic [2:0] {
		COND_NORMAL = 3'h1,
		COND_START = 3'h2,
		COND_TRIP = 3'h4
	} cond_t;

	typedef struct packed {
		logic vld;
		logic [1:0] code;
		logic [`AGG_STAMP_W-1:0] stamp;
	} event_rec_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`AGG_APB_AW-1:0] paddr;
		logic [`AGG_APB_DW-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic [`AGG_APB_DW-1:0] prdata;
		logic pslverr;
	} apb_rsp_t;
endpackage

// file: core/time_base.sv
// Millisecond time base used to stamp aggregator events.
`timescale 1ns/1ps
`default_nettype none
`include "agg_defines.svh"

module time_base #(
	parameter int unsigned TICK_CYCLES = `AGG_TICK_CYCLES
) (
	input wire logic clk, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	output logic [`AGG_STAMP_W-1:0] stamp // Running time in ticks.
);
	logic [31:0] div_ff;
	logic [`AGG_STAMP_W-1:0] stamp_ff;
	wire tick = (div_ff == 32'(TICK_CYCLES - 1));

	// Divider makes a one-cycle tick enable; the stamp simply wraps when full.
	always_ff @(posedge clk) begin
		if (srst) begin
			div_ff <= 32'h0000_0000;
			stamp_ff <= '0;
		end else begin
			div_ff <= tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
			if (tick) begin
				stamp_ff <= stamp_ff + 1'b1;
			end
		end
	end

	assign stamp = stamp_ff;
endmodule // time_base
`default_nettype wire

// file: core/event_logger.sv
// Edge detector that turns a level into filtered, time-stamped ON and OFF events.
`timescale 1ns/1ps
`default_nettype none
`include "agg_defines.svh"

module event_logger #(
	parameter logic [1:0] ON_CODE = `AGG_EVT_START_ON,
	parameter logic [1:0] OFF_CODE = `AGG_EVT_START_OFF
) (
	input wire logic clk, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic level, // Watched level, from a flop.
	input wire logic rec_on, // Record ON events.
	input wire logic rec_off, // Record OFF events.
	input wire logic [`AGG_STAMP_W-1:0] stamp, // Current time.
	output logic rise, // Level rose this cycle.
	output logic fall, // Level fell this cycle.
	output agg_pkg::event_rec_t evt // Recorded event, one-cycle valid.
);
	import agg_pkg::*;

	logic prev_ff;
	event_rec_t evt_ff;

	// Edges are seen against last cycle's level, which resets low to avoid a false OFF.
	assign rise = level & ~prev_ff;
	assign fall = ~level & prev_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			prev_ff <= 1'b0;
			evt_ff <= '0;
		end else begin
			prev_ff <= level;
			evt_ff.vld <= (rise & rec_on) | (fall & rec_off);
			evt_ff.code <= rise ? ON_CODE : OFF_CODE;
			evt_ff.stamp <= stamp;
		end
	end

	assign evt = evt_ff;
endmodule // event_logger
`default_nettype wire

// file: core/common_start_trip_aggregator.sv
// Common start and trip aggregator with forcing, event logging, counters and an APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "agg_defines.svh"

// Summary of operation
// - Common start/trip follow any activated protection function's start/trip.
// - Assigned extra start inputs also raise common start.
// - Assigned extra trip inputs also raise common trip.
// - Force selector Normal, Start or Trip overrides status; resets to Normal.
// - Force selector only takes effect while global stage forcing is permitted.
// - General settings are static and do not follow setting groups.
// - The aggregator has no blocking input; blocking is per protection function.
// - Every rise and fall of start and trip makes one of four events.
// - Each event code can be recorded or dropped on its own.
// - Start and trip counters accumulate rises and can be cleared by software.
// - Every recorded event carries a time stamp.
// - A read-only condition shows Normal, Start or Trip.
// - Common outputs go out for output control and user logic.
module common_start_trip_aggregator #(
	parameter int N_PROT = 16,
	parameter int N_EXTRA = 8,
	parameter int CNT_W = 32,
	parameter int unsigned TICK_CYCLES = `AGG_TICK_CYCLES
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire agg_pkg::apb_req_t apb_req, // APB request from the master.
	output agg_pkg::apb_rsp_t apb_rsp, // APB response, registered.
	input wire logic [N_PROT-1:0] prot_active, // Protection function activated.
	input wire logic [N_PROT-1:0] prot_start, // Protection function start.
	input wire logic [N_PROT-1:0] prot_trip, // Protection function trip.
	input wire logic [N_EXTRA-1:0] extra_start, // Extra start signals.
	input wire logic [N_EXTRA-1:0] extra_trip, // Extra trip signals.
	input wire logic stage_force_en, // Global stage forcing permission.
	output logic agg_start, // Common start output.
	output logic agg_trip, // Common trip output.
	output agg_pkg::event_rec_t evt_start, // Common start ON/OFF event.
	output agg_pkg::event_rec_t evt_trip, // Common trip ON/OFF event.
	output logic irq // Level interrupt.
);
	import agg_pkg::*;

	// Reset image of the control word; the record field is cut from it by position.
	localparam logic [`AGG_APB_DW-1:0] CTRL_RESET = `AGG_CTRL_RESET;

	// Saturating increment keeps a counter from wrapping back to a small value.
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	// Byte address compare, shared by every register decode.
	function automatic logic hit(input logic [`AGG_APB_AW-1:0] a, input logic [`AGG_APB_AW-1:0] o);
		hit = (a == o);
	endfunction

	force_sel_t force_sel_ff;
	logic [`AGG_N_EVT-1:0] rec_en_ff;
	logic [N_EXTRA-1:0] xstart_assign_ff;
	logic [N_EXTRA-1:0] xtrip_assign_ff;
	logic [`AGG_N_EVT-1:0] irq_status_ff;
	logic [`AGG_N_EVT-1:0] irq_mask_ff;
	logic [CNT_W-1:0] start_cnt_ff;
	logic [CNT_W-1:0] trip_cnt_ff;
	logic agg_start_ff;
	logic agg_trip_ff;
	cond_t cond_ff;
	logic irq_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [`AGG_APB_DW-1:0] prdata_ff;
	logic [`AGG_STAMP_W-1:0] stamp;
	logic start_rise;
	logic start_fall;
	logic trip_rise;
	logic trip_fall;

	// APB decode. Every access is answered in its first access cycle.
	wire setup = apb_req.psel & ~apb_req.penable;
	wire access = apb_req.psel & apb_req.penable & pready_ff;
	wire wr_en = access & apb_req.pwrite;
	wire [`AGG_APB_AW-1:0] addr = apb_req.paddr;
	wire [`AGG_APB_DW-1:0] wdata = apb_req.pwdata;
	wire hit_ctrl = hit(addr, `AGG_OFF_CTRL);
	wire hit_status = hit(addr, `AGG_OFF_STATUS);
	wire hit_scnt = hit(addr, `AGG_OFF_START_CNT);
	wire hit_tcnt = hit(addr, `AGG_OFF_TRIP_CNT);
	wire hit_clr = hit(addr, `AGG_OFF_CNT_CLR);
	wire hit_xs = hit(addr, `AGG_OFF_XSTART_ASSIGN);
	wire hit_xt = hit(addr, `AGG_OFF_XTRIP_ASSIGN);
	wire hit_ist = hit(addr, `AGG_OFF_IRQ_STATUS);
	wire hit_imask = hit(addr, `AGG_OFF_IRQ_MASK);
	wire hit_time = hit(addr, `AGG_OFF_TIME);
	wire mapped = hit_ctrl | hit_status | hit_scnt | hit_tcnt | hit_clr | hit_xs | hit_xt
		| hit_ist | hit_imask | hit_time;

	// Forcing is only honoured while the global permission is on.
	wire force_ok = stage_force_en;
	wire force_sel_t eff_force = force_ok ? force_sel_ff : FORCE_NORMAL;

	// Plain OR of all sources; there is deliberately no blocking term here.
	wire prot_start_any = |(prot_start & prot_active);
	wire prot_trip_any = |(prot_trip & prot_active);
	wire extra_start_any = |(extra_start & xstart_assign_ff);
	wire extra_trip_any = |(extra_trip & xtrip_assign_ff);
	wire raw_start = prot_start_any | extra_start_any;
	wire raw_trip = prot_trip_any | extra_trip_any;

	// Forcing overrides every input while it is in effect.
	wire nxt_agg_start = (eff_force == FORCE_START) ? 1'b1 :
		(eff_force == FORCE_TRIP) ? 1'b0 : raw_start;
	wire nxt_agg_trip = (eff_force == FORCE_TRIP) ? 1'b1 :
		(eff_force == FORCE_START) ? 1'b0 : raw_trip;
	wire cond_t nxt_cond = nxt_agg_trip ? COND_TRIP : nxt_agg_start ? COND_START : COND_NORMAL;

	// Software strobes taken from the write that completes at this edge.
	wire clr_start = wr_en & hit_clr & wdata[`AGG_CLR_START_BIT];
	wire clr_trip = wr_en & hit_clr & wdata[`AGG_CLR_TRIP_BIT];
	wire [`AGG_N_EVT-1:0] evt_set = {trip_fall, trip_rise, start_fall, start_rise};
	wire [`AGG_N_EVT-1:0] ist_clr = (wr_en & hit_ist) ? wdata[`AGG_N_EVT-1:0] : '0;
	// Set wins over a same-cycle write-one-to-clear so no event is lost.
	wire [`AGG_N_EVT-1:0] nxt_irq_status = (irq_status_ff & ~ist_clr) | evt_set;
	wire [`AGG_N_EVT-1:0] nxt_irq_mask = (wr_en & hit_imask) ? wdata[`AGG_N_EVT-1:0] : irq_mask_ff;

	// Counters: a rise in the clearing cycle counts as the first of the new run.
	wire [CNT_W-1:0] start_base = clr_start ? '0 : start_cnt_ff;
	wire [CNT_W-1:0] trip_base = clr_trip ? '0 : trip_cnt_ff;
	wire [CNT_W-1:0] nxt_start_cnt = start_rise ? sat_inc(start_base) : start_base;
	wire [CNT_W-1:0] nxt_trip_cnt = trip_rise ? sat_inc(trip_base) : trip_base;

	// Read mux; unmapped addresses read zero and flag an error.
	logic [`AGG_APB_DW-1:0] rd_data;
	always_comb begin
		rd_data = '0;
		if (hit_ctrl) begin
			rd_data[`AGG_CTRL_FORCE_MSB:`AGG_CTRL_FORCE_LSB] = force_sel_ff;
			rd_data[`AGG_CTRL_REC_MSB:`AGG_CTRL_REC_LSB] = rec_en_ff;
		end else if (hit_status) begin
			rd_data[`AGG_STAT_COND_MSB:`AGG_STAT_COND_LSB] = cond_ff;
			rd_data[`AGG_STAT_START_BIT] = agg_start_ff;
			rd_data[`AGG_STAT_TRIP_BIT] = agg_trip_ff;
			rd_data[`AGG_STAT_FORCE_OK_BIT] = force_ok;
		end else if (hit_scnt) begin
			rd_data[CNT_W-1:0] = start_cnt_ff;
		end else if (hit_tcnt) begin
			rd_data[CNT_W-1:0] = trip_cnt_ff;
		end else if (hit_xs) begin
			rd_data[N_EXTRA-1:0] = xstart_assign_ff;
		end else if (hit_xt) begin
			rd_data[N_EXTRA-1:0] = xtrip_assign_ff;
		end else if (hit_ist) begin
			rd_data[`AGG_N_EVT-1:0] = irq_status_ff;
		end else if (hit_imask) begin
			rd_data[`AGG_N_EVT-1:0] = irq_mask_ff;
		end else if (hit_time) begin
			rd_data[`AGG_STAMP_W-1:0] = stamp;
		end
	end

	// APB handshake: the answer is built in setup and shown with pready in access.
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff <= (setup & ~apb_req.pwrite) ? rd_data : '0;
		end
	end

	// Static configuration. No setting group input exists, so nothing can switch it.
	always_ff @(posedge clk) begin
		if (srst) begin
			force_sel_ff <= FORCE_NORMAL;
			rec_en_ff <= CTRL_RESET[`AGG_CTRL_REC_MSB:`AGG_CTRL_REC_LSB];
			xstart_assign_ff <= '0;
			xtrip_assign_ff <= '0;
		end else if (wr_en) begin
			// The selector only accepts legal codes while forcing is permitted.
			if (hit_ctrl && force_ok && wdata[`AGG_CTRL_FORCE_MSB:`AGG_CTRL_FORCE_LSB] != 2'h3) begin
				force_sel_ff <= force_sel_t'(wdata[`AGG_CTRL_FORCE_MSB:`AGG_CTRL_FORCE_LSB]);
			end
			if (hit_ctrl) begin
				rec_en_ff <= wdata[`AGG_CTRL_REC_MSB:`AGG_CTRL_REC_LSB];
			end
			if (hit_xs) begin
				xstart_assign_ff <= wdata[N_EXTRA-1:0];
			end
			if (hit_xt) begin
				xtrip_assign_ff <= wdata[N_EXTRA-1:0];
			end
		end
	end

	// Common outputs and condition are registered so downstream sees clean levels.
	always_ff @(posedge clk) begin
		if (srst) begin
			agg_start_ff <= 1'b0;
			agg_trip_ff <= 1'b0;
			cond_ff <= COND_NORMAL;
		end else begin
			agg_start_ff <= nxt_agg_start;
			agg_trip_ff <= nxt_agg_trip;
			cond_ff <= nxt_cond;
		end
	end

	// Counters, interrupt status, mask and the registered interrupt line.
	always_ff @(posedge clk) begin
		if (srst) begin
			start_cnt_ff <= '0;
			trip_cnt_ff <= '0;
			irq_status_ff <= '0;
			irq_mask_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			start_cnt_ff <= nxt_start_cnt;
			trip_cnt_ff <= nxt_trip_cnt;
			irq_status_ff <= nxt_irq_status;
			irq_mask_ff <= nxt_irq_mask;
			irq_ff <= |(nxt_irq_status & nxt_irq_mask);
		end
	end

	time_base #(.TICK_CYCLES(TICK_CYCLES)) u_time (
		.clk(clk),
		.srst(srst),
		.stamp(stamp)
	);

	// One logger per output gives the four ON/OFF codes, each with its stamp.
	event_logger #(.ON_CODE(`AGG_EVT_START_ON), .OFF_CODE(`AGG_EVT_START_OFF)) u_start_log (
		.clk(clk),
		.srst(srst),
		.level(agg_start_ff),
		.rec_on(rec_en_ff[`AGG_EVT_START_ON]),
		.rec_off(rec_en_ff[`AGG_EVT_START_OFF]),
		.stamp(stamp),
		.rise(start_rise),
		.fall(start_fall),
		.evt(evt_start)
	);

	event_logger #(.ON_CODE(`AGG_EVT_TRIP_ON), .OFF_CODE(`AGG_EVT_TRIP_OFF)) u_trip_log (
		.clk(clk),
		.srst(srst),
		.level(agg_trip_ff),
		.rec_on(rec_en_ff[`AGG_EVT_TRIP_ON]),
		.rec_off(rec_en_ff[`AGG_EVT_TRIP_OFF]),
		.stamp(stamp),
		.rise(trip_rise),
		.fall(trip_fall),
		.evt(evt_trip)
	);

	assign agg_start = agg_start_ff;
	assign agg_trip = agg_trip_ff;
	assign irq = irq_ff;
	// One assignment for the whole response keeps the port variable single-driven.
	assign apb_rsp = '{pready: pready_ff, prdata: prdata_ff, pslverr: pslverr_ff};

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_prot_start_out: assert property (
		(eff_force == FORCE_NORMAL && prot_start_any) |=> agg_start_ff
	) else $error("Protection start did not raise common start.");

	chk_prot_trip_out: assert property (
		(eff_force == FORCE_NORMAL && prot_trip_any) |=> agg_trip_ff
	) else $error("Protection trip did not raise common trip.");

	chk_extra_start_in: assert property (
		(eff_force == FORCE_NORMAL && extra_start_any) |=> agg_start_ff
	) else $error("Assigned extra start did not raise common start.");

	chk_extra_trip_in: assert property (
		(eff_force == FORCE_NORMAL && extra_trip_any) |=> agg_trip_ff && cond_ff == COND_TRIP
	) else $error("Assigned extra trip did not raise common trip.");

	chk_force_start_out: assert property (
		(force_ok && force_sel_ff == FORCE_START) |=> agg_start_ff && !agg_trip_ff
	) else $error("Forced start not shown on the outputs.");

	chk_force_gate_off: assert property (
		(!stage_force_en && !raw_start && !raw_trip) |=> !agg_start_ff && !agg_trip_ff
	) else $error("Force selector acted without permission.");

	chk_start_count_up: assert property (
		($rose(agg_start_ff) && !clr_start && !(&start_cnt_ff))
			|=> start_cnt_ff == $past(start_cnt_ff) + 1'b1
	) else $error("Start counter did not count a rise.");

	chk_trip_event_on: assert property (
		($rose(agg_trip_ff) && rec_en_ff[`AGG_EVT_TRIP_ON])
			|=> evt_trip.vld && evt_trip.code == `AGG_EVT_TRIP_ON && evt_trip.stamp == $past(stamp)
	) else $error("Trip ON event missing or wrong.");

	chk_event_filter_off: assert property (
		($fell(agg_start_ff) && !rec_en_ff[`AGG_EVT_START_OFF]) |=> !evt_start.vld
	) else $error("Disabled start OFF event was recorded.");

	chk_cond_normal_idle: assert property (
		(!agg_start_ff && !agg_trip_ff) |-> cond_ff == COND_NORMAL
	) else $error("Condition not Normal while outputs idle.");
endmodule // common_start_trip_aggregator
`default_nettype wire

// file: test/prot_source_model.sv
// Behavioural model of the protection functions and user logic that feed the aggregator.
`timescale 1ns/1ps
`default_nettype none

module prot_source_model #(
	parameter int N_PROT = 16,
	parameter int N_EXTRA = 8
) (
	input wire logic clk, // System clock.
	output logic [N_PROT-1:0] prot_active, // Function activated.
	output logic [N_PROT-1:0] prot_start, // Function start.
	output logic [N_PROT-1:0] prot_trip, // Function trip.
	output logic [N_EXTRA-1:0] extra_start, // Extra start signals.
	output logic [N_EXTRA-1:0] extra_trip // Extra trip signals.
);
	// All functions start quiet, so the aggregator leaves reset in Normal.
	initial begin
		prot_active = '0;
		prot_start = '0;
		prot_trip = '0;
		extra_start = '0;
		extra_trip = '0;
	end

	// Changes land just after an edge, like a function block updating once a cycle.
	task automatic set_fn(input int idx, input logic act, input logic st, input logic tr);
		@(posedge clk);
		prot_active[idx] <= act;
		prot_start[idx] <= st;
		prot_trip[idx] <= tr;
	endtask

	// Extra inputs come from user logic and are moved as whole vectors.
	task automatic set_extra(input logic [N_EXTRA-1:0] st, input logic [N_EXTRA-1:0] tr);
		@(posedge clk);
		extra_start <= st;
		extra_trip <= tr;
	endtask
endmodule // prot_source_model

`default_nettype wire

// file: test/testbench.sv
// Self-checking testbench of the common start and trip aggregator.
`timescale 1ns/1ps
`default_nettype none
`include "agg_defines.svh"

module testbench;
	import agg_pkg::*;

	logic clk = 1'b0;
	logic srst = 1'b1;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [15:0] p_act, p_st, p_tr;
	logic [7:0] x_st, x_tr;
	logic stage_force_en = 1'b0;
	logic agg_start, agg_trip, irq;
	event_rec_t evt_start, evt_trip;
	int n_errors = 0;
	int checked = 0;
	int ev_cnt [4] = '{0, 0, 0, 0};
	logic [31:0] last_stamp = '0;
	logic [31:0] rd;
	logic err;

	// A short tick keeps stamps moving within a brief run.
	common_start_trip_aggregator #(.TICK_CYCLES(4)) common_start_trip_aggregator_i (
		.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
		.prot_active(p_act), .prot_start(p_st), .prot_trip(p_tr),
		.extra_start(x_st), .extra_trip(x_tr), .stage_force_en(stage_force_en),
		.agg_start(agg_start), .agg_trip(agg_trip),
		.evt_start(evt_start), .evt_trip(evt_trip), .irq(irq));

	prot_source_model #(.N_PROT(16), .N_EXTRA(8)) prot_source_model_i (
		.clk(clk), .prot_active(p_act), .prot_start(p_st), .prot_trip(p_tr),
		.extra_start(x_st), .extra_trip(x_tr));

	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk = ~clk;
	end

	// Tally recorded events by code, since they may arrive during a bus transfer.
	always @(posedge clk) begin
		if (evt_start.vld === 1'b1) begin
			ev_cnt[evt_start.code]++;
			last_stamp <= evt_start.stamp;
		end
		if (evt_trip.vld === 1'b1) begin
			ev_cnt[evt_trip.code]++;
			last_stamp <= evt_trip.stamp;
		end
	end

	task automatic check_bit(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; the wait is bounded so a dead slave shows as a mismatch.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= addr;
		req.pwdata <= wdata;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		check_bit("pready", 1'b1, rsp.pready);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		check_word(what, exp, rd);
	endtask

	task automatic t_reset();
		rd_chk("ctrl reset", `AGG_OFF_CTRL, `AGG_CTRL_RESET);
		rd_chk("status reset", `AGG_OFF_STATUS, 32'h0000_0001);
		rd_chk("start count reset", `AGG_OFF_START_CNT, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check_bit("unmapped error", 1'b1, err);
		$display("test reset done");
	endtask

	task automatic t_prot();
		int base [4];
		logic [31:0] t0;
		base = ev_cnt;
		prot_source_model_i.set_fn(7, 1'b0, 1'b1, 1'b0);
		step(2);
		check_bit("start of inactive function", 1'b0, agg_start);
		apb(1'b0, `AGG_OFF_TIME, 32'h0);
		t0 = rd;
		prot_source_model_i.set_fn(7, 1'b1, 1'b1, 1'b0);
		step(2);
		check_bit("common start", 1'b1, agg_start);
		rd_chk("status start", `AGG_OFF_STATUS, 32'h0000_0012);
		apb(1'b0, `AGG_OFF_TIME, 32'h0);
		check_bit("stamp in window", 1'b1, last_stamp >= t0 && last_stamp <= rd);
		prot_source_model_i.set_fn(15, 1'b1, 1'b0, 1'b1);
		step(2);
		check_bit("common trip", 1'b1, agg_trip);
		rd_chk("status trip", `AGG_OFF_STATUS, 32'h0000_0034);
		prot_source_model_i.set_fn(7, 1'b0, 1'b0, 1'b0);
		prot_source_model_i.set_fn(15, 1'b0, 1'b0, 1'b0);
		step(4);
		check_bit("start released", 1'b0, agg_start);
		for (int i = 0; i < 4; i++) begin
			check_word("event count", 32'(base[i] + 1), 32'(ev_cnt[i]));
		end
		rd_chk("start count", `AGG_OFF_START_CNT, 32'h1);
		$display("test protection inputs done");
	endtask

	task automatic t_extra();
		prot_source_model_i.set_extra(8'h04, 8'h80);
		step(2);
		check_bit("unassigned extra start", 1'b0, agg_start);
		check_bit("unassigned extra trip", 1'b0, agg_trip);
		apb(1'b1, `AGG_OFF_XSTART_ASSIGN, 32'h0000_0004);
		apb(1'b1, `AGG_OFF_XTRIP_ASSIGN, 32'h0000_0080);
		step(2);
		check_bit("extra start", 1'b1, agg_start);
		check_bit("extra trip", 1'b1, agg_trip);
		prot_source_model_i.set_extra(8'h00, 8'h00);
		step(2);
		check_bit("extra trip released", 1'b0, agg_trip);
		$display("test extra inputs done");
	endtask

	task automatic t_force();
		prot_source_model_i.set_fn(3, 1'b1, 1'b0, 1'b1);
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F1);
		step(2);
		check_bit("force without permission", 1'b0, agg_start);
		rd_chk("ctrl unchanged", `AGG_OFF_CTRL, 32'h0000_00F0);
		@(posedge clk);
		stage_force_en <= 1'b1;
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F1);
		step(2);
		check_bit("forced start", 1'b1, agg_start);
		check_bit("trip under forced start", 1'b0, agg_trip);
		rd_chk("status forced start", `AGG_OFF_STATUS, 32'h0000_0052);
		prot_source_model_i.set_fn(3, 1'b1, 1'b1, 1'b0);
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F2);
		step(2);
		check_bit("forced trip", 1'b1, agg_trip);
		check_bit("start under forced trip", 1'b0, agg_start);
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F3);
		rd_chk("illegal force code", `AGG_OFF_CTRL, 32'h0000_00F2);
		@(posedge clk);
		stage_force_en <= 1'b0;
		step(2);
		check_bit("kept force dormant", 1'b0, agg_trip);
		check_bit("inputs rule unpermitted", 1'b1, agg_start);
		@(posedge clk);
		stage_force_en <= 1'b1;
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F0);
		step(2);
		check_bit("normal follows inputs", 1'b1, agg_start);
		check_bit("normal trip follows", 1'b0, agg_trip);
		prot_source_model_i.set_fn(3, 1'b0, 1'b0, 1'b0);
		stage_force_en <= 1'b0;
		step(4);
		$display("test forcing done");
	endtask

	task automatic t_record();
		int base [4];
		for (int m = 0; m < 2; m++) begin
			base = ev_cnt;
			apb(1'b1, `AGG_OFF_CTRL, (m == 1) ? 32'h0000_00A0 : 32'h0000_0050);
			prot_source_model_i.set_fn(1, 1'b1, 1'b1, 1'b1);
			step(4);
			prot_source_model_i.set_fn(1, 1'b0, 1'b0, 1'b0);
			step(4);
			for (int i = 0; i < 4; i++) begin
				check_word("recorded events", 32'((i % 2) == m), 32'(ev_cnt[i] - base[i]));
			end
		end
		apb(1'b1, `AGG_OFF_CTRL, 32'h0000_00F0);
		$display("test record enables done");
	endtask

	task automatic t_irq_count();
		apb(1'b1, `AGG_OFF_CNT_CLR, 32'h0000_0003);
		rd_chk("start count cleared", `AGG_OFF_START_CNT, 32'h0);
		rd_chk("trip count cleared", `AGG_OFF_TRIP_CNT, 32'h0);
		apb(1'b1, `AGG_OFF_IRQ_STATUS, 32'h0000_000F);
		apb(1'b1, `AGG_OFF_IRQ_MASK, 32'h0000_0001);
		step(2);
		check_bit("irq idle", 1'b0, irq);
		prot_source_model_i.set_fn(2, 1'b1, 1'b0, 1'b1);
		step(4);
		check_bit("masked irq", 1'b0, irq);
		rd_chk("irq status", `AGG_OFF_IRQ_STATUS, 32'h0000_0004);
		prot_source_model_i.set_fn(2, 1'b1, 1'b1, 1'b1);
		step(4);
		check_bit("irq raised", 1'b1, irq);
		apb(1'b1, `AGG_OFF_IRQ_STATUS, 32'h0000_0001);
		step(2);
		check_bit("irq cleared", 1'b0, irq);
		rd_chk("trip count", `AGG_OFF_TRIP_CNT, 32'h1);
		rd_chk("start count", `AGG_OFF_START_CNT, 32'h1);
		prot_source_model_i.set_fn(2, 1'b0, 1'b0, 1'b0);
		$display("test interrupt and counters done");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The whole run takes a few hundred cycles; the watchdog allows far more.
	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired");
		end_of_test();
	end

	// Main sequence.
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_prot();
		t_extra();
		t_force();
		t_record();
		t_irq_count();
		end_of_test();
	end
endmodule // testbench

`default_nettype wire
